/* File: jtp_pkg.sv */
// Shared constants and types for the programming test access port.
package jtp_pkg;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam int             IR_W        = 4;
  localparam logic [IR_W-1:0] IR_EXTEST   = 4'h0;
  localparam logic [IR_W-1:0] IR_IDCODE   = 4'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE   = 4'h2;
  localparam logic [IR_W-1:0] IR_PROG_EN  = 4'h4;
  localparam logic [IR_W-1:0] IR_PROG_CMD = 4'h5;
  localparam logic [IR_W-1:0] IR_PAGE_RD  = 4'h7;
  localparam logic [IR_W-1:0] IR_RESET    = 4'hC;
  localparam logic [IR_W-1:0] IR_BYPASS   = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;

  // ****************************************
  // Data register layouts
  // ****************************************
  localparam int          ID_W     = 32;
  localparam int          PEN_W    = 16;
  localparam logic [15:0] PEN_SIG  = 16'hA370;
  localparam logic [15:0] PEN_RST  = 16'h0000;
  localparam int          CMD_W    = 15;
  localparam int          OP_MSB   = 14;
  localparam int          OP_LSB   = 12;
  localparam logic [2:0]  OP_ADR_H = 3'h3;
  localparam logic [2:0]  OP_ADR_L = 3'h1;
  localparam int          ARG_W    = 8;
  localparam int          BYTE_W   = 8;
  localparam int          WORD_W   = 16;
  localparam int          PC_W     = 16;
  localparam int          FIFO_D   = 16;
  localparam int          TOUT_W   = 20;

  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR,
    S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR,
    S_PAU_IR, S_EX2_IR, S_UPD_IR
  } jtp_tap_t;

endpackage

/* File: jtp_tap.sv */
// Programming test access port with flash read path and word FIFO.
`timescale 1ns/100ps

// ****************************************
// Word FIFO
// ****************************************
module jtp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // System side
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;

  assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) &&
                       (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (in_valid && in_ready) wr_reg <= wr_reg + 1'b1;
      if (out_valid && out_ready) rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule

// Overview of operation
// - TAP state machine on TCK and TMS picks IR or one DR path.
// - Instruction register selects the active data register and its behaviour.
// - Identifier, bypass and boundary-scan registers serve board testing.
// - Reset, enable, command and flash byte registers each have an instruction.
// - Page read captures alternate low then high bytes, low first after entry.
// - Program counter steps after each high byte, starting at loaded address.
// - Flash byte register shifts one bit per TCK in Shift-DR.
// - A one in the reset register holds the part in reset.
// - After reset bit clears, reset lasts a fuse-selected time-out.
// - Reset register acts at once, not latched at Update-DR.
// - Programming enabled only while enable register equals the signature.
// - Enable register clears to zero on power-on reset.
module jtp_tap #(
  parameter logic [31:0] ID_CODE = 32'h0000_0001, // Arbitrary value.
  parameter int          BSR_LEN = 8,
  parameter int          TOUT0   = 16,
  parameter int          TOUT1   = 256,
  parameter int          TOUT2   = 4096,
  parameter int          TOUT3   = 65536
) (
  // System clock and power-on reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Test access port
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output      logic               tdo_out,
  output      logic               tdo_oe,
  // Boundary scan
  input  wire logic [BSR_LEN-1:0] bs_pins_in,
  output      logic [BSR_LEN-1:0] bs_pins_out,
  output      logic               bs_drive,
  // Part reset
  input  wire logic [1:0]         clk_opt_fuse,
  output      logic               part_reset_n,
  // Programming status and commands
  output      logic               prog_enabled,
  output      logic [14:0]        cmd_data,
  output      logic               cmd_valid,
  // Flash read port
  output      logic [15:0]        flash_addr,
  output      logic               flash_rd_req,
  input  wire logic               flash_rd_ack,
  input  wire logic [15:0]        flash_rd_data
);

  // ****************************************
  // TAP controller
  // ****************************************
  function automatic jtp_pkg::jtp_tap_t tap_next(jtp_pkg::jtp_tap_t s,
                                                 logic m);
    unique case (s)
      jtp_pkg::S_TLR:    tap_next = m ? jtp_pkg::S_TLR    : jtp_pkg::S_RTI;
      jtp_pkg::S_RTI:    tap_next = m ? jtp_pkg::S_SEL_DR : jtp_pkg::S_RTI;
      jtp_pkg::S_SEL_DR: tap_next = m ? jtp_pkg::S_SEL_IR : jtp_pkg::S_CAP_DR;
      jtp_pkg::S_CAP_DR: tap_next = m ? jtp_pkg::S_EX1_DR : jtp_pkg::S_SH_DR;
      jtp_pkg::S_SH_DR:  tap_next = m ? jtp_pkg::S_EX1_DR : jtp_pkg::S_SH_DR;
      jtp_pkg::S_EX1_DR: tap_next = m ? jtp_pkg::S_UPD_DR : jtp_pkg::S_PAU_DR;
      jtp_pkg::S_PAU_DR: tap_next = m ? jtp_pkg::S_EX2_DR : jtp_pkg::S_PAU_DR;
      jtp_pkg::S_EX2_DR: tap_next = m ? jtp_pkg::S_UPD_DR : jtp_pkg::S_SH_DR;
      jtp_pkg::S_UPD_DR: tap_next = m ? jtp_pkg::S_SEL_DR : jtp_pkg::S_RTI;
      jtp_pkg::S_SEL_IR: tap_next = m ? jtp_pkg::S_TLR    : jtp_pkg::S_CAP_IR;
      jtp_pkg::S_CAP_IR: tap_next = m ? jtp_pkg::S_EX1_IR : jtp_pkg::S_SH_IR;
      jtp_pkg::S_SH_IR:  tap_next = m ? jtp_pkg::S_EX1_IR : jtp_pkg::S_SH_IR;
      jtp_pkg::S_EX1_IR: tap_next = m ? jtp_pkg::S_UPD_IR : jtp_pkg::S_PAU_IR;
      jtp_pkg::S_PAU_IR: tap_next = m ? jtp_pkg::S_EX2_IR : jtp_pkg::S_PAU_IR;
      jtp_pkg::S_EX2_IR: tap_next = m ? jtp_pkg::S_UPD_IR : jtp_pkg::S_SH_IR;
      jtp_pkg::S_UPD_IR: tap_next = m ? jtp_pkg::S_SEL_DR : jtp_pkg::S_RTI;
    endcase
  endfunction

  jtp_pkg::jtp_tap_t state_reg;
  logic [3:0]  ir_reg, ir_sh_reg;
  logic        cap, sh, upd, prog_en, page_sel;
  logic        byp_reg, rst_dr_reg, tdo_mux;
  logic [31:0] id_reg;
  logic [15:0] pen_reg;
  logic [14:0] cmd_sh_reg, cmd_word_reg;
  logic        cmd_tgl_reg, cons_tgl_reg, byte_hi_reg, seen_reg;
  logic [7:0]  fbyte_reg;
  logic        pr_act_reg, pen_ok_reg, hold_s1, hold_s2;
  logic [BSR_LEN-1:0] bsr_reg, bsr_upd_reg, pin_s1, pin_s2;
  logic        hold_tgl_reg, hold_valid_reg;
  logic [15:0] hold_word_reg;

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) state_reg <= jtp_pkg::S_TLR;
    else state_reg <= tap_next(state_reg, tms);
  end

  assign cap      = (state_reg == jtp_pkg::S_CAP_DR);
  assign sh       = (state_reg == jtp_pkg::S_SH_DR);
  assign upd      = (state_reg == jtp_pkg::S_UPD_DR);
  assign prog_en  = (pen_reg == jtp_pkg::PEN_SIG);
  assign page_sel = (ir_reg == jtp_pkg::IR_PAGE_RD) && prog_en;

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg    <= jtp_pkg::IR_IDCODE;
      ir_sh_reg <= jtp_pkg::IR_CAPTURE;
    end else begin
      unique case (state_reg)
        jtp_pkg::S_TLR:    ir_reg <= jtp_pkg::IR_IDCODE;
        jtp_pkg::S_CAP_IR: ir_sh_reg <= jtp_pkg::IR_CAPTURE;
        jtp_pkg::S_SH_IR:  ir_sh_reg <= {tdi, ir_sh_reg[3:1]};
        jtp_pkg::S_UPD_IR: ir_reg <= ir_sh_reg;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Board test registers
  // ****************************************
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= bs_pins_in;
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      byp_reg <= 1'b0;
      id_reg  <= '0;
    end else if (ir_reg == jtp_pkg::IR_IDCODE) begin
      if (cap) id_reg <= ID_CODE;
      else if (sh) id_reg <= {tdi, id_reg[31:1]};
    end else if (ir_reg == jtp_pkg::IR_BYPASS) begin
      if (cap) byp_reg <= 1'b0;
      else if (sh) byp_reg <= tdi;
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      bsr_reg     <= '0;
      bsr_upd_reg <= '0;
    end else if (ir_reg == jtp_pkg::IR_EXTEST ||
                 ir_reg == jtp_pkg::IR_SAMPLE) begin
      if (cap) bsr_reg <= pin_s2;
      else if (sh) bsr_reg <= {tdi, bsr_reg[BSR_LEN-1:1]};
      else if (upd) bsr_upd_reg <= bsr_reg;
    end
  end

  assign bs_pins_out = bsr_upd_reg;
  assign bs_drive    = (ir_reg == jtp_pkg::IR_EXTEST);

  // ****************************************
  // Programming registers
  // ****************************************
  // The reset bit shifts straight through with no update stage.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) rst_dr_reg <= 1'b0;
    else if (sh && ir_reg == jtp_pkg::IR_RESET) rst_dr_reg <= tdi;
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) pen_reg <= jtp_pkg::PEN_RST;
    else if (sh && ir_reg == jtp_pkg::IR_PROG_EN)
      pen_reg <= {tdi, pen_reg[15:1]};
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      cmd_sh_reg   <= '0;
      cmd_word_reg <= '0;
      cmd_tgl_reg  <= 1'b0;
    end else if (ir_reg == jtp_pkg::IR_PROG_CMD && prog_en) begin
      if (sh) cmd_sh_reg <= {tdi, cmd_sh_reg[14:1]};
      else if (upd) begin
        cmd_word_reg <= cmd_sh_reg;
        cmd_tgl_reg  <= !cmd_tgl_reg;
      end
    end
  end

  // ****************************************
  // Flash byte register
  // ****************************************
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end else begin
      hold_s1 <= hold_tgl_reg;
      hold_s2 <= hold_s1;
    end
  end

  // The held word is stable whenever the toggles differ.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      byte_hi_reg  <= 1'b0;
      seen_reg     <= 1'b0;
      cons_tgl_reg <= 1'b0;
    end else if (state_reg == jtp_pkg::S_UPD_IR) begin
      byte_hi_reg <= 1'b0;
      seen_reg    <= hold_s2;
    end else if (cap && page_sel && hold_s2 != seen_reg) begin
      byte_hi_reg <= !byte_hi_reg;
      if (byte_hi_reg) begin
        seen_reg     <= hold_s2;
        cons_tgl_reg <= !cons_tgl_reg;
      end
    end
  end

  // A capture with no word ready yields zero and does not advance.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) fbyte_reg <= '0;
    else if (page_sel) begin
      if (cap) begin
        if (hold_s2 == seen_reg) fbyte_reg <= '0;
        else if (byte_hi_reg) fbyte_reg <= hold_word_reg[15:8];
        else fbyte_reg <= hold_word_reg[7:0];
      end else if (sh) fbyte_reg <= {tdi, fbyte_reg[7:1]};
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      pr_act_reg <= 1'b0;
      pen_ok_reg <= 1'b0;
    end else begin
      pr_act_reg <= page_sel;
      pen_ok_reg <= prog_en;
    end
  end

  always_comb begin
    unique case (ir_reg)
      jtp_pkg::IR_EXTEST, jtp_pkg::IR_SAMPLE: tdo_mux = bsr_reg[0];
      jtp_pkg::IR_IDCODE:   tdo_mux = id_reg[0];
      jtp_pkg::IR_PROG_EN:  tdo_mux = pen_reg[0];
      jtp_pkg::IR_PROG_CMD: tdo_mux = cmd_sh_reg[0];
      jtp_pkg::IR_PAGE_RD:  tdo_mux = fbyte_reg[0];
      jtp_pkg::IR_RESET:    tdo_mux = rst_dr_reg;
      default:              tdo_mux = byp_reg;
    endcase
  end

  // TDO changes on the falling edge so the probe samples it settled.
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out <= 1'b0;
      tdo_oe  <= 1'b0;
    end else begin
      tdo_out <= (state_reg == jtp_pkg::S_SH_IR) ? ir_sh_reg[0] : tdo_mux;
      tdo_oe  <= sh || (state_reg == jtp_pkg::S_SH_IR);
    end
  end

  // ****************************************
  // System side crossings
  // ****************************************
  logic [4:0] s1_reg, s2_reg;
  logic       pr_d_reg, cmd_seen_reg, cons_seen_reg;
  logic       cmd_evt, cons_evt, pr_rise, flush, ld_h, ld_l;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {rst_dr_reg, pr_act_reg, pen_ok_reg, cmd_tgl_reg,
                 cons_tgl_reg};
      s2_reg <= s1_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pr_d_reg      <= 1'b0;
      cmd_seen_reg  <= 1'b0;
      cons_seen_reg <= 1'b0;
      cmd_valid     <= 1'b0;
      cmd_data      <= '0;
    end else begin
      pr_d_reg      <= s2_reg[3];
      cmd_seen_reg  <= s2_reg[1];
      cons_seen_reg <= s2_reg[0];
      cmd_valid     <= cmd_evt;
      if (cmd_evt) cmd_data <= cmd_word_reg;
    end
  end

  assign prog_enabled = s2_reg[2];
  assign cmd_evt  = s2_reg[1] != cmd_seen_reg;
  assign cons_evt = s2_reg[0] != cons_seen_reg;
  assign pr_rise  = s2_reg[3] && !pr_d_reg;
  assign ld_h = cmd_evt &&
    cmd_word_reg[jtp_pkg::OP_MSB:jtp_pkg::OP_LSB] == jtp_pkg::OP_ADR_H;
  assign ld_l = cmd_evt &&
    cmd_word_reg[jtp_pkg::OP_MSB:jtp_pkg::OP_LSB] == jtp_pkg::OP_ADR_L;
  assign flush = pr_rise || ld_h || ld_l;

  // ****************************************
  // Program counter and prefetch
  // ****************************************
  logic [15:0] pc_reg, pc_next, fetch_reg;
  logic        busy_reg, stale_reg, f_in_rdy, f_out_vld, f_out_rdy;
  logic [15:0] f_out_data;

  always_comb begin
    pc_next = pc_reg;
    if (ld_h) pc_next = {cmd_word_reg[7:0], pc_reg[7:0]};
    else if (ld_l) pc_next = {pc_reg[15:8], cmd_word_reg[7:0]};
    else if (cons_evt) pc_next = pc_reg + 16'h0001;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pc_reg <= '0;
    else pc_reg <= pc_next;
  end

  // A read in flight at a flush is marked stale and dropped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg  <= 1'b0;
      stale_reg <= 1'b0;
      fetch_reg <= '0;
    end else begin
      if (flash_rd_ack) busy_reg <= 1'b0;
      else if (!busy_reg && s2_reg[3] && f_in_rdy && !flush)
        busy_reg <= 1'b1;
      if (flush) stale_reg <= busy_reg && !flash_rd_ack;
      else if (flash_rd_ack) stale_reg <= 1'b0;
      if (flush) fetch_reg <= pc_next;
      else if (flash_rd_ack && busy_reg) fetch_reg <= fetch_reg + 16'h0001;
    end
  end

  assign flash_rd_req = busy_reg;
  assign flash_addr   = fetch_reg;

  jtp_fifo #(.W(jtp_pkg::WORD_W), .D(jtp_pkg::FIFO_D)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (flash_rd_ack && busy_reg && !stale_reg),
    .in_ready  (f_in_rdy),
    .in_data   (flash_rd_data),
    .out_valid (f_out_vld),
    .out_ready (f_out_rdy),
    .out_data  (f_out_data)
  );

  assign f_out_rdy = s2_reg[3] && !flush && (!hold_valid_reg || cons_evt);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_valid_reg <= 1'b0;
      hold_tgl_reg   <= 1'b0;
      hold_word_reg  <= '0;
    end else if (flush) hold_valid_reg <= 1'b0;
    else if (f_out_vld && f_out_rdy) begin
      hold_word_reg  <= f_out_data;
      hold_valid_reg <= 1'b1;
      hold_tgl_reg   <= !hold_tgl_reg;
    end else if (cons_evt) hold_valid_reg <= 1'b0;
  end

  // ****************************************
  // Part reset and time-out
  // ****************************************
  logic [19:0] tout_cnt_reg, tout_sel;
  logic        part_rst_n_reg;

  always_comb begin
    unique case (clk_opt_fuse)
      2'h0: tout_sel = TOUT0[19:0];
      2'h1: tout_sel = TOUT1[19:0];
      2'h2: tout_sel = TOUT2[19:0];
      2'h3: tout_sel = TOUT3[19:0];
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tout_cnt_reg   <= '0;
      part_rst_n_reg <= 1'b0;
    end else begin
      if (s2_reg[4]) tout_cnt_reg <= tout_sel;
      else if (tout_cnt_reg != '0) tout_cnt_reg <= tout_cnt_reg - 20'h1;
      part_rst_n_reg <= !(s2_reg[4] || tout_cnt_reg != '0);
    end
  end

  // Assertion is immediate from the bit; release waits for the time-out.
  assign part_reset_n = part_rst_n_reg && !rst_dr_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_tms_hi5;
    tms [*5];
  endsequence
  a_tap_reset_tms: assert property (@(posedge tck) disable iff (!rst_n)
    s_tms_hi5 |=> state_reg == jtp_pkg::S_TLR) else $error("TAP not reset");
  a_ir_update_load: assert property (@(posedge tck) disable iff (!rst_n)
    state_reg == jtp_pkg::S_UPD_IR |=> ir_reg == $past(ir_sh_reg))
    else $error("IR not loaded");
  a_id_capture: assert property (@(posedge tck) disable iff (!rst_n)
    cap && ir_reg == jtp_pkg::IR_IDCODE |=> id_reg == ID_CODE)
    else $error("ID not captured");
  a_cmd_update_tgl: assert property (@(posedge tck) disable iff (!rst_n)
    upd && prog_en && ir_reg == jtp_pkg::IR_PROG_CMD |=> $changed(cmd_tgl_reg))
    else $error("Command not sent");
  a_byte_low_first: assert property (@(posedge tck) disable iff (!rst_n)
    state_reg == jtp_pkg::S_UPD_IR |=> !byte_hi_reg) else $error("Not low");
  a_pc_step_hi: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cons_evt && !ld_h && !ld_l |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("PC did not step");
  a_fbyte_shift: assert property (@(posedge tck) disable iff (!rst_n)
    sh && page_sel |=> fbyte_reg == {$past(tdi), $past(fbyte_reg[7:1])})
    else $error("Byte not shifted");
  a_rst_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_dr_reg |-> !part_reset_n) else $error("Reset not held");
  a_rst_timeout: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(s2_reg[4]) && tout_cnt_reg > 20'h1 |=> !part_rst_n_reg [*2])
    else $error("Time-out too short");
  a_pen_gate: assert property (@(posedge tck) disable iff (!rst_n)
    pen_reg != jtp_pkg::PEN_SIG |=> !pr_act_reg && !pen_ok_reg)
    else $error("Enabled without signature");
  a_pen_por: assert property (@(posedge tck) disable iff (!rst_n)
    $rose(rst_n) |-> pen_reg == jtp_pkg::PEN_RST) else $error("Enable set");
  a_pen_keep: assert property (@(posedge tck) disable iff (!rst_n)
    ir_reg != jtp_pkg::IR_PROG_EN |=> $stable(pen_reg))
    else $error("Unselected register changed");
  a_rst_shift: assert property (@(posedge tck) disable iff (!rst_n)
    sh && ir_reg == jtp_pkg::IR_RESET |=> rst_dr_reg == $past(tdi))
    else $error("Reset bit not direct");

endmodule

/* File: jtp_flash_model.sv */
// Flash memory stand-in that answers word reads after a set latency.
`timescale 1ns/100ps
module jtp_flash_model (
  // System side
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        slow,
  // Read port
  input  wire logic        flash_rd_req,
  input  wire logic [15:0] flash_addr,
  output      logic        flash_rd_ack,
  output      logic [15:0] flash_rd_data
);
  logic [3:0] wait_reg;

  // Between answers the bus shows a changing pattern, so stale data is
  // never mistaken for a fresh word.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg      <= 4'h0;
      flash_rd_ack  <= 1'b0;
      flash_rd_data <= 16'hFFFF;
    end else if (flash_rd_req && !flash_rd_ack &&
                 wait_reg >= (slow ? 4'h5 : 4'h0)) begin
      wait_reg      <= 4'h0;
      flash_rd_ack  <= 1'b1;
      flash_rd_data <= flash_addr ^ 16'h5A3C;
    end else begin
      wait_reg      <= flash_rd_req ? wait_reg + 4'h1 : 4'h0;
      flash_rd_ack  <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule

/* File: tb_jtp_tap.sv */
// Self-checking bench for the programming test access port.
`timescale 1ns/100ps
module tb_jtp_tap;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        tck = 1'b0;
  logic        tms = 1'b1;
  logic        tdi = 1'b0;
  logic        slow = 1'b0;
  logic        tdo_out, tdo_oe, bs_drive, part_reset_n, prog_enabled;
  logic        cmd_valid, flash_rd_req, flash_rd_ack;
  logic [7:0]  bs_pins_out;
  logic [14:0] cmd_data, last_cmd;
  logic [15:0] flash_addr, flash_rd_data;
  logic [31:0] q;
  int          err_total = 0, num_checks = 0, n_cmd = 0, cyc = 0;

  jtp_tap #(.TOUT0(64)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .bs_pins_in(8'h5A),
    .bs_pins_out(bs_pins_out), .bs_drive(bs_drive), .clk_opt_fuse(2'h0),
    .part_reset_n(part_reset_n), .prog_enabled(prog_enabled),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .flash_addr(flash_addr),
    .flash_rd_req(flash_rd_req), .flash_rd_ack(flash_rd_ack),
    .flash_rd_data(flash_rd_data));
  jtp_flash_model flash (
    .clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
    .flash_rd_req(flash_rd_req), .flash_addr(flash_addr),
    .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data));

  // ****************************************
  // Link transfers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Apart from one pulse during reset, the test clock only runs inside transfers and idles low.
  task automatic tk(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    o = tdo_out;
    #80 tck = 1'b0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] d);
    logic o;
    tk(1'b1, 1'b0, o);
    if (ir) tk(1'b1, 1'b0, o);
    tk(1'b0, 1'b0, o);
    tk(1'b0, 1'b0, o);
    q = 32'h0;
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, d[i], o);
      q[i] = o;
    end
    tk(1'b1, 1'b0, o);
    tk(1'b0, 1'b0, o);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ident();
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_IDCODE});
    chk(q, {28'h0, jtp_pkg::IR_CAPTURE});
    scan(1'b0, 32, 32'h0);
    chk(q, 32'h0000_0001);
    chk(tdo_oe, 1'b0);
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_SAMPLE});
    scan(1'b0, 8, 32'h3C);
    chk(q, 32'h5A);
    chk(bs_pins_out, 8'h3C);
    chk(bs_drive, 1'b0);
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_EXTEST});
    chk(bs_drive, 1'b1);
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_BYPASS});
    scan(1'b0, 8, 32'hB5);
    chk(q, 32'h6A);
  endtask
  task automatic t_reset();
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_RESET});
    scan(1'b0, 1, 32'h1);
    chk(part_reset_n, 1'b0);
    repeat (200) @(negedge clk_sys);
    chk(part_reset_n, 1'b0);
    scan(1'b0, 1, 32'h0);
    chk(part_reset_n, 1'b0);
    repeat (80) @(negedge clk_sys);
    chk(part_reset_n, 1'b1);
  endtask
  task automatic t_enable();
    chk(prog_enabled, 1'b0);
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_PROG_EN});
    scan(1'b0, 16, 32'hA371);
    chk(prog_enabled, 1'b0);
    scan(1'b0, 16, 32'hA370);
    chk(prog_enabled, 1'b1);
  endtask
  task automatic t_read();
    logic [15:0] w;
    logic        o;
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_PROG_CMD});
    scan(1'b0, 15, 32'h3000);
    scan(1'b0, 15, 32'h10FF);
    chk(n_cmd, 2);
    chk(last_cmd, 15'h10FF);
    slow = 1'b1;
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_PAGE_RD});
    // The page read flag only reaches the system side on a test clock edge.
    repeat (3) tk(1'b0, 1'b0, o);
    repeat (300) @(negedge clk_sys);
    chk(flash_rd_req, 1'b0);
    chk(flash_addr, 16'h0110);
    for (int k = 0; k < 4; k++) begin
      scan(1'b0, 8, 32'h0);
      w = (k < 2 ? 16'h00FF : 16'h0100) ^ 16'h5A3C;
      chk(q, k[0] ? w[15:8] : w[7:0]);
    end
    chk(prog_enabled, 1'b1);
    scan(1'b1, 4, {28'h0, jtp_pkg::IR_PROG_EN});
    scan(1'b0, 16, 32'h0);
    chk(prog_enabled, 1'b0);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_data;
    end
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    logic o;
    #23 tck = 1'b1;
    #8 tck = 1'b0;
    #9 rst_n = 1'b1;
    repeat (5) tk(1'b1, 1'b0, o);
    tk(1'b0, 1'b0, o);
    t_ident();
    t_reset();
    t_enable();
    t_read();
    give_verdict();
  end
endmodule
